// *** design/pdseq_pkg.sv ***
// package for the powered-device detect and classify sequencer
`default_nettype none
package pdseq_pkg;
   // ----------------------------------------
   // clock and timing
   // ----------------------------------------
   localparam int unsigned CLK_HZ          = 20_000_000;
   localparam int unsigned TICK_HZ         = 1000;
   localparam int unsigned TICK_DIV        = CLK_HZ / TICK_HZ;
   localparam int unsigned BACKOFF_MS      = 100;
   localparam int unsigned MIDSPAN_MS      = 2000;
   localparam int unsigned CLASS_EVENT_MS  = 12;
   localparam int unsigned MARK_PAUSE_MS   = 10;
   localparam int unsigned MEAS_STEP_MS    = 20;
   // ----------------------------------------
   // register map
   // ----------------------------------------
   localparam logic [3:0] REG_CTRL     = 4'h0;
   localparam logic [3:0] REG_CMD      = 4'h1;
   localparam logic [3:0] REG_STATUS   = 4'h2;
   localparam logic [3:0] REG_HPSTAT   = 4'h3;
   localparam logic [3:0] REG_ICUT     = 4'h4;
   localparam logic [3:0] REG_ILIM     = 4'h5;
   localparam logic [3:0] REG_FAULT    = 4'h6;
   // ctrl field positions
   localparam int unsigned CTRL_MODE_LO = 0;
   localparam int unsigned CTRL_DET_EN  = 2;
   localparam int unsigned CTRL_CLS_EN  = 3;
   localparam int unsigned CTRL_LEGACY  = 4;
   localparam int unsigned CTRL_TWO_EV  = 5;
   localparam int unsigned CTRL_HIPWR   = 6;
   // command bits
   localparam int unsigned CMD_DETECT   = 0;
   localparam int unsigned CMD_CLASSIFY = 1;
   localparam int unsigned CMD_PWR_ON   = 2;
   localparam int unsigned CMD_PWR_OFF  = 3;
   localparam logic [7:0]  CTRL_RESET   = 8'h00;
   // ----------------------------------------
   // port operating mode field
   // ----------------------------------------
   localparam logic [1:0] MODE_SHUTDOWN = 2'b00;
   localparam logic [1:0] MODE_MANUAL   = 2'b01;
   localparam logic [1:0] MODE_SEMI     = 2'b10;
   localparam logic [1:0] MODE_AUTO     = 2'b11;
   // ----------------------------------------
   // detection outcomes and classes
   // ----------------------------------------
   typedef enum logic [2:0] {
      DET_UNKNOWN = 3'h0, DET_SHORT = 3'h1, DET_CAP_HIGH = 3'h2, DET_R_LOW = 3'h3,
      DET_GOOD = 3'h4, DET_R_HIGH = 3'h5, DET_OPEN = 3'h6, DET_V_RANGE = 3'h7
   } pdseq_det_type;
   localparam logic [2:0] CLASS_0 = 3'h0;
   localparam logic [2:0] CLASS_3 = 3'h3;
   localparam logic [2:0] CLASS_4 = 3'h4;
   // ----------------------------------------
   // automatic thresholds, in ma
   // ----------------------------------------
   localparam logic [9:0] ICUT_C1 = 10'd112;
   localparam logic [9:0] ICUT_C2 = 10'd206;
   localparam logic [9:0] ICUT_C3 = 10'd375;
   localparam logic [9:0] ICUT_C4 = 10'd638;
   localparam logic [9:0] ILIM_LO = 10'd425;
   localparam logic [9:0] ILIM_HI = 10'd850;
   // ----------------------------------------
   // front-end drive and verdicts
   // ----------------------------------------
   typedef enum logic [2:0] {
      DRV_OFF = 3'h0, DRV_I1 = 3'h1, DRV_I2 = 3'h2, DRV_V1 = 3'h3,
      DRV_V2 = 3'h4, DRV_CLASS = 3'h5, DRV_MARK = 3'h6
   } pdseq_drv_type;
   typedef struct packed {
      logic       low_volt;
      logic       r_valid;
      logic       cap_high;
      logic [2:0] verdict;
      logic [2:0] class_band;
   } pdseq_meas_type;
   typedef struct packed {
      logic [3:0] addr;
      logic [9:0] wdata;
      logic       wr;
      logic       rd;
   } pdseq_bus_type;
endpackage
`default_nettype wire

// *** design/pdseq_timer.sv ***
// millisecond tick divider and down-counter for sequencer waits
`default_nettype none
module pdseq_timer #(
   parameter int unsigned DIV = pdseq_pkg::TICK_DIV
) (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        reset,
   // control
   input  wire logic        load,
   input  wire logic [11:0] load_ms,
   // status
   output logic             expired
);
   import pdseq_pkg::*;
   typedef struct packed {
      logic [15:0] div;
      logic [11:0] ms;
      logic        exp;
   } pdseq_tmr_type;
   pdseq_tmr_type s_q, s_d;
   logic tick;
   assign tick    = (s_q.div == 16'h0000);
   assign expired = s_q.exp;
   always_comb begin
      s_d = s_q;
      s_d.div = tick ? 16'(DIV - 1) : s_q.div - 16'h0001;
      if (load) begin
         s_d.ms  = load_ms;
         s_d.exp = 1'b0;
         s_d.div = 16'(DIV - 1);
      end else if (tick && !s_q.exp) begin
         if (s_q.ms <= 12'h001) begin
            s_d.exp = 1'b1;
            s_d.ms  = 12'h000;
         end else begin
            s_d.ms = s_q.ms - 12'h001;
         end
      end
   end
   always_ff @(posedge clk) begin
      if (reset) begin
         s_q <= '{div: 16'h0000, ms: 12'h000, exp: 1'b1};
      end else begin
         s_q <= s_d;
      end
   end
endmodule
`default_nettype wire

// *** design/pdseq_core.sv ***
// detect and classify sequencer for one power-sourcing port
// ----------------------------------------
// ----------------------------------------
`default_nettype none
module pdseq_core #(
   parameter int unsigned TICK_CYCLES = pdseq_pkg::TICK_DIV
) (
   // clock and reset
   input  wire logic                     clk,
   input  wire logic                     reset,
   // configuration pins
   input  wire logic                     auto_pin,
   input  wire logic                     mid_pin,
   // register port
   input  wire pdseq_pkg::pdseq_bus_type bus,
   output logic [9:0]                    rdata,
   // analog front end
   input  wire pdseq_pkg::pdseq_meas_type meas,
   output pdseq_pkg::pdseq_drv_type      port_output_pin,
   output logic                          power_on
);
   import pdseq_pkg::*;
   // ----------------------------------------
   // state
   // ----------------------------------------
   typedef enum logic [3:0] {
      ST_IDLE = 4'h0, ST_I1 = 4'h1, ST_I2 = 4'h3, ST_V1 = 4'h2, ST_V2 = 4'h6,
      ST_CLS1 = 4'h7, ST_MARK = 4'h5, ST_CLS2 = 4'h4, ST_BACKOFF = 4'hc
   } pdseq_st_type;
   typedef struct packed {
      pdseq_st_type  st;
      logic [7:0]    ctrl;
      logic          auto_ok;
      logic          mid_ok;
      logic          strap_done;
      logic          manual_once;
      pdseq_det_type det;
      logic [2:0]    cls;
      logic          first_c4;
      logic          second_run;
      logic [9:0]    icut;
      logic [9:0]    ilim;
      logic          start_fault;
      logic          pwr;
      pdseq_drv_type drv;
      logic [9:0]    rdata;
      logic          tload;
      logic [11:0]   tms;
   } pdseq_state_type;
   pdseq_state_type s_q, s_d;
   logic auto_m, auto_s, mid_m, mid_s, t_exp;
   logic [1:0] mode;
   logic detect_on, cls_on, auto_md;
   // ----------------------------------------
   // pin synchronisers
   // ----------------------------------------
   // kept out of reset: the straps must be through both stages when reset lets go
   always_ff @(posedge clk) begin
      auto_m <= auto_pin;
      auto_s <= auto_m;
      mid_m  <= mid_pin;
      mid_s  <= mid_m;
   end
   pdseq_timer #(.DIV(TICK_CYCLES)) u_timer (
      .clk     (clk),
      .reset   (reset),
      .load    (s_q.tload),
      .load_ms (s_q.tms),
      .expired (t_exp)
   );
   // 11b without the auto strap is reserved and behaves as shutdown
   function automatic logic [1:0] eff_mode(input logic [1:0] m, input logic a);
      eff_mode = (m == MODE_AUTO && !a) ? MODE_SHUTDOWN : m;
   endfunction
   function automatic logic [9:0] cut_of(input logic [2:0] c);
      case (c)
         3'h1:    cut_of = ICUT_C1;
         3'h2:    cut_of = ICUT_C2;
         CLASS_4: cut_of = ICUT_C4;
         default: cut_of = ICUT_C3;  // class 0 as class 3
      endcase
   endfunction
   assign mode      = eff_mode(s_q.ctrl[CTRL_MODE_LO +: 2], s_q.auto_ok);
   assign auto_md   = (mode == MODE_AUTO);
   assign detect_on = (mode != MODE_SHUTDOWN) && s_q.ctrl[CTRL_DET_EN];
   assign cls_on    = s_q.ctrl[CTRL_CLS_EN];
   // ----------------------------------------
   // next state
   // ----------------------------------------
   always_comb begin
      s_d = s_q;
      s_d.tload = 1'b0;
      s_d.rdata = 10'h000;
      // strap sampled once after reset release
      if (!s_q.strap_done) begin
         s_d.strap_done = 1'b1;
         s_d.auto_ok    = auto_s;
         s_d.mid_ok     = mid_s;
         // standalone use: automatic mode with detection and classes on
         if (auto_s) begin
            s_d.ctrl = 8'h6f;
         end
      end
      // register writes
      if (bus.wr) begin
         case (bus.addr)
            REG_CTRL: s_d.ctrl = bus.wdata[7:0];
            REG_CMD: begin
               if (bus.wdata[CMD_DETECT] && mode == MODE_MANUAL) begin
                  s_d.manual_once = 1'b1;
               end
               if (bus.wdata[CMD_PWR_ON] && mode != MODE_SHUTDOWN && !auto_md) begin
                  if (mode == MODE_SEMI && s_q.ctrl[CTRL_HIPWR] && s_q.det != DET_GOOD) begin
                     s_d.start_fault = 1'b1;
                  end else begin
                     s_d.pwr = 1'b1;
                  end
               end
               if (bus.wdata[CMD_PWR_OFF]) begin
                  s_d.pwr = 1'b0;
               end
            end
            REG_ICUT: s_d.icut = bus.wdata;
            REG_ILIM: s_d.ilim = bus.wdata;
            REG_FAULT: s_d.start_fault = 1'b0;
            default: ;
         endcase
      end
      if (bus.rd) begin
         case (bus.addr)
            REG_CTRL:   s_d.rdata = {2'b00, s_q.ctrl};
            REG_STATUS: s_d.rdata = {1'b0, s_q.pwr, 2'b00, s_q.cls, s_q.det};
            REG_HPSTAT: s_d.rdata = {9'h000, s_q.second_run};
            REG_ICUT:   s_d.rdata = s_q.icut;
            REG_ILIM:   s_d.rdata = s_q.ilim;
            REG_FAULT:  s_d.rdata = {9'h000, s_q.start_fault};
            default:    s_d.rdata = 10'h000;
         endcase
      end
      if (mode == MODE_SHUTDOWN) begin
         s_d.pwr = 1'b0;
      end
      // sequencer
      case (s_q.st)
         ST_IDLE: begin
            s_d.drv = DRV_OFF;
            if (detect_on && !s_q.pwr &&
                (mode != MODE_MANUAL || s_q.manual_once)) begin
               // a detect command landing in this same cycle stays armed for the next run
               s_d.manual_once = bus.wr && bus.addr == REG_CMD && bus.wdata[CMD_DETECT] &&
                                 mode == MODE_MANUAL;
               s_d.st    = ST_I1;
               s_d.drv   = DRV_I1;
               s_d.tload = 1'b1;
               s_d.tms   = 12'(MEAS_STEP_MS);
            end else if (mode == MODE_MANUAL && cls_on && bus.wr && bus.addr == REG_CMD &&
                         bus.wdata[CMD_CLASSIFY] && !s_q.pwr) begin
               s_d.st    = ST_CLS1;
               s_d.drv   = DRV_CLASS;
               s_d.tload = 1'b1;
               s_d.tms   = 12'(CLASS_EVENT_MS);
               s_d.first_c4   = 1'b0;
               s_d.second_run = 1'b0;
            end
         end
         ST_I1: if (t_exp && !s_q.tload) begin
            if (meas.low_volt) begin
               s_d.det = DET_SHORT;
               s_d.st  = ST_BACKOFF;
               s_d.drv = DRV_OFF;
               s_d.tload = 1'b1;
               s_d.tms = s_q.mid_ok ? 12'(MIDSPAN_MS) : 12'(BACKOFF_MS);
            end else begin
               s_d.st  = ST_I2;
               s_d.drv = DRV_I2;
               s_d.tload = 1'b1;
               s_d.tms = 12'(MEAS_STEP_MS);
            end
         end
         ST_I2: if (t_exp && !s_q.tload) begin
            if (meas.r_valid) begin
               s_d.st  = ST_V1;
               s_d.drv = DRV_V1;
               s_d.tms = 12'(MEAS_STEP_MS);
            end else begin
               if (meas.cap_high && s_q.ctrl[CTRL_LEGACY]) begin
                  s_d.det = DET_GOOD;
               end else begin
                  s_d.det = pdseq_det_type'(meas.verdict);
               end
               s_d.st  = ST_BACKOFF;
               s_d.drv = DRV_OFF;
               s_d.tms = s_q.mid_ok ? 12'(MIDSPAN_MS) : 12'(BACKOFF_MS);
            end
            s_d.tload = 1'b1;
         end
         ST_V1: if (t_exp && !s_q.tload) begin
            s_d.st  = ST_V2;
            s_d.drv = DRV_V2;
            s_d.tload = 1'b1;
            s_d.tms = 12'(MEAS_STEP_MS);
         end
         ST_V2: if (t_exp && !s_q.tload) begin
            s_d.tload = 1'b1;
            if (meas.r_valid) begin
               s_d.det = DET_GOOD;
               if (cls_on && mode != MODE_MANUAL) begin
                  s_d.st  = ST_CLS1;
                  s_d.drv = DRV_CLASS;
                  s_d.tms = 12'(CLASS_EVENT_MS);
                  s_d.first_c4   = 1'b0;
                  s_d.second_run = 1'b0;
               end else begin
                  if (auto_md) begin
                     s_d.pwr  = 1'b1;
                     s_d.icut = ICUT_C3;
                     s_d.ilim = ILIM_LO;
                  end
                  s_d.st  = ST_BACKOFF;
                  s_d.drv = DRV_OFF;
                  s_d.tms = s_q.mid_ok ? 12'(MIDSPAN_MS) : 12'(BACKOFF_MS);
               end
            end else begin
               // a non-good verdict from the front end keeps its own code
               s_d.det = (meas.verdict == DET_GOOD) ? DET_UNKNOWN :
                         pdseq_det_type'(meas.verdict);
               s_d.st  = ST_BACKOFF;
               s_d.drv = DRV_OFF;
               s_d.tms = s_q.mid_ok ? 12'(MIDSPAN_MS) : 12'(BACKOFF_MS);
            end
         end
         ST_CLS1, ST_CLS2: if (t_exp && !s_q.tload) begin
            s_d.cls   = meas.class_band;
            s_d.tload = 1'b1;
            if (s_q.st == ST_CLS1 && meas.class_band == CLASS_4 && s_q.ctrl[CTRL_TWO_EV]) begin
               s_d.first_c4 = 1'b1;
               s_d.st  = ST_MARK;
               s_d.drv = DRV_MARK;
               s_d.tms = 12'(MARK_PAUSE_MS);
            end else begin
               s_d.st  = ST_BACKOFF;
               s_d.drv = DRV_OFF;
               s_d.tms = s_q.mid_ok ? 12'(MIDSPAN_MS) : 12'(BACKOFF_MS);
               if (auto_md && s_q.det == DET_GOOD &&
                   !(s_q.first_c4 && meas.class_band != CLASS_4)) begin
                  s_d.pwr  = 1'b1;
                  s_d.icut = cut_of(meas.class_band);
                  s_d.ilim = (meas.class_band == CLASS_4) ? ILIM_HI : ILIM_LO;
               end
            end
         end
         ST_MARK: if (t_exp && !s_q.tload) begin
            s_d.second_run = 1'b1;
            s_d.st  = ST_CLS2;
            s_d.drv = DRV_CLASS;
            s_d.tload = 1'b1;
            s_d.tms = 12'(CLASS_EVENT_MS);
         end
         ST_BACKOFF: if (t_exp && !s_q.tload) begin
            s_d.st = ST_IDLE;
         end
         default: s_d.st = ST_IDLE;
      endcase
   end
   // ----------------------------------------
   // registers and outputs
   // ----------------------------------------
   always_ff @(posedge clk) begin
      if (reset) begin
         s_q <= '{st: ST_IDLE, ctrl: CTRL_RESET, det: DET_UNKNOWN, drv: DRV_OFF,
                  icut: ICUT_C3, ilim: ILIM_LO, tms: 12'h000, rdata: 10'h000,
                  cls: CLASS_0, default: 1'b0};
      end else begin
         s_q <= s_d;
      end
   end
   assign rdata           = s_q.rdata;
   assign port_output_pin = s_q.drv;
   assign power_on        = s_q.pwr;
   // ----------------------------------------
   // checks
   // ----------------------------------------
   a_short_abort: assert property (@(posedge clk) disable iff (reset)
      (s_q.st == ST_I1 && t_exp && !s_q.tload && meas.low_volt) |=>
      (s_q.det == DET_SHORT && s_q.st == ST_BACKOFF)) else $error("short not aborted");
   a_volt_after_cur: assert property (@(posedge clk) disable iff (reset)
      (s_q.st == ST_V1) |-> $past(s_q.st) inside {ST_I2, ST_V1})
      else $error("forced voltage without current phase");
   a_second_flag: assert property (@(posedge clk) disable iff (reset)
      (s_q.st == ST_CLS2) |-> (s_q.second_run && s_q.first_c4 && s_q.ctrl[CTRL_TWO_EV]))
      else $error("second class without class 4");
   a_no_bad_pwr: assert property (@(posedge clk) disable iff (reset)
      ($rose(s_q.pwr) && auto_md) |-> !(s_q.first_c4 && s_q.cls != CLASS_4))
      else $error("invalid type 2 powered");
   a_hp_refuse: assert property (@(posedge clk) disable iff (reset)
      (bus.wr && bus.addr == REG_CMD && bus.wdata[CMD_PWR_ON] && mode == MODE_SEMI &&
       s_q.ctrl[CTRL_HIPWR] && s_q.det != DET_GOOD && !s_q.pwr) |=> (!s_q.pwr && s_q.start_fault))
      else $error("semi-auto high power powered without good");
   a_no_detect_off: assert property (@(posedge clk) disable iff (reset)
      (s_q.st == ST_IDLE && !detect_on) |=> s_q.st != ST_I1)
      else $error("detection while inhibited");
   a_class_thresh: assert property (@(posedge clk) disable iff (reset)
      ($rose(s_q.pwr) && auto_md && s_q.cls == CLASS_4 && s_q.st == ST_BACKOFF) |->
      (s_q.icut == ICUT_C4 && s_q.ilim == ILIM_HI)) else $error("class 4 thresholds");
   a_class_time: assert property (@(posedge clk) disable iff (reset)
      $rose(s_q.st == ST_CLS1) |-> (s_q.drv == DRV_CLASS)[*8])
      else $error("class voltage dropped early");
   a_semi_no_pwr: assert property (@(posedge clk) disable iff (reset)
      ($rose(s_q.pwr) && mode == MODE_SEMI) |->
      $past(bus.wr && bus.addr == REG_CMD && bus.wdata[CMD_PWR_ON]))
      else $error("semi-auto powered by itself");
   c_good_detect: cover property (@(posedge clk) s_q.st == ST_V2 ##1 s_q.det == DET_GOOD);
   c_two_event:   cover property (@(posedge clk) s_q.st == ST_MARK ##1 s_q.st == ST_CLS2);
   c_auto_power:  cover property (@(posedge clk) $rose(s_q.pwr) && auto_md);
   c_short:       cover property (@(posedge clk) $rose(s_q.det == DET_SHORT));
   c_refused:     cover property (@(posedge clk) s_q.st == ST_CLS2 ##1
      (s_q.st == ST_BACKOFF && !s_q.pwr && s_q.cls != CLASS_4));
endmodule
`default_nettype wire

// *** testbench/pdseq_fe_model.sv ***
// front end and powered device model feeding measurement verdicts
`default_nettype none
module pdseq_fe_model (
   // clock
   input  wire logic                     clk,
   // scenario knobs
   input  wire logic                     sig_ok,
   input  wire logic                     shorted,
   input  wire logic [2:0]               cls,
   // front end
   input  wire pdseq_pkg::pdseq_drv_type drv,
   output pdseq_pkg::pdseq_meas_type     meas
);
   timeunit 1ns;
   timeprecision 1ns;
   import pdseq_pkg::*;
   logic tog = 1'b0;
   always @(posedge clk) tog <= ~tog;
   always_comb begin
      // nothing is measured between steps, so the lines churn
      meas = {9{tog}};
      if (drv != DRV_OFF) begin
         meas.low_volt   = shorted && (drv == DRV_I1);
         meas.r_valid    = sig_ok;
         meas.cap_high   = 1'b0;
         meas.verdict    = sig_ok ? DET_GOOD : DET_OPEN;
         meas.class_band = (drv == DRV_CLASS) ? cls : 3'h0;
      end
   end
endmodule
`default_nettype wire

// *** testbench/tb.sv ***
// self-checking bench for the detect and classify sequencer
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   import pdseq_pkg::*;
   localparam logic [9:0] DET = 10'(1 << CTRL_DET_EN);
   localparam logic [9:0] HIP = 10'(1 << CTRL_HIPWR);
   localparam logic [9:0] CEN = 10'(1 << CTRL_CLS_EN);
   // short millisecond so whole detect and class cycles fit the run
   localparam int unsigned TICK = 10;
   logic           clk = 1'b0;
   logic           reset = 1'b1;
   logic           auto_pin = 1'b0;
   logic           mid_pin = 1'b0;
   logic           sig_ok = 1'b1;
   logic           shorted = 1'b0;
   logic [2:0]     cls = 3'h3;
   pdseq_bus_type  bus = '0;
   logic [9:0]     rdata;
   pdseq_drv_type  drv;
   pdseq_meas_type meas;
   logic           power_on;
   int             miscompares = 0;
   int             checked = 0;
   logic [9:0]     inhibit [3] = '{10'(MODE_SEMI), DET | 10'(MODE_SHUTDOWN), DET | 10'(MODE_AUTO)};
   always #25 clk = ~clk;
   pdseq_core #(.TICK_CYCLES(TICK)) dut (.clk(clk), .reset(reset), .auto_pin(auto_pin),
      .mid_pin(mid_pin), .bus(bus), .rdata(rdata), .meas(meas), .port_output_pin(drv),
      .power_on(power_on));
   pdseq_fe_model fe (.clk(clk), .sig_ok(sig_ok), .shorted(shorted), .cls(cls), .drv(drv),
      .meas(meas));
   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic chk(input string what, input logic [9:0] exp, input logic [9:0] got);
      checked++;
      if (got !== exp) begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [9:0] d);
      @(posedge clk);
      bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk);
      bus.wr <= 1'b0;
   endtask
   task automatic rdchk(input logic [3:0] a, input logic [9:0] exp, input string what);
      @(posedge clk);
      bus <= '{addr: a, wdata: 10'h0, wr: 1'b0, rd: 1'b1};
      @(posedge clk);
      bus.rd <= 1'b0;
      #1;
      chk(what, exp, rdata);
   endtask
   // checks every cycle that no step starts and no power is applied
   task automatic quiet(input string what);
      repeat (40) begin
         @(posedge clk);
         #1;
         chk(what, 10'h0, {6'h0, power_on, drv});
      end
   endtask
   task automatic wait_drv(input pdseq_drv_type exp, input string what);
      int n;
      n = 0;
      while (drv !== exp && n < 2000) begin
         @(posedge clk);
         #1;
         n++;
      end
      chk(what, 10'(exp), 10'(drv));
      if (drv !== exp) end_of_test();
   endtask
   // straps must be steady well before release, so they move with reset
   task automatic do_reset(input logic ap);
      @(posedge clk);
      auto_pin <= ap;
      mid_pin <= ap;
      reset <= 1'b1;
      repeat (8) @(posedge clk);
      reset <= 1'b0;
      repeat (2) @(posedge clk);
   endtask
   initial begin
      do_reset(1'b0);
      rdchk(REG_CTRL, {2'h0, CTRL_RESET}, "ctrl reset");
      rdchk(REG_STATUS, 10'h0, "status reset");
      rdchk(4'hf, 10'h0, "unmapped read");
      $display("test reset done");
      foreach (inhibit[i]) begin
         wr(REG_CTRL, inhibit[i]);
         quiet("inhibited detect");
      end
      wr(REG_CTRL, DET | 10'(MODE_MANUAL));
      quiet("manual idle");
      wr(REG_CMD, 10'(1 << CMD_DETECT));
      wait_drv(DRV_I1, "manual detect start");
      chk("manual no power", 10'h0, 10'(power_on));
      $display("test modes done");
      do_reset(1'b0);
      shorted <= 1'b1;
      wr(REG_CTRL, HIP | CEN | DET | 10'(MODE_SEMI));
      wait_drv(DRV_I1, "semi poll start");
      chk("semi no power", 10'h0, 10'(power_on));
      wait_drv(DRV_OFF, "short abort");
      rdchk(REG_STATUS, 10'h001, "short status");
      repeat (BACKOFF_MS * TICK - 50) @(posedge clk);
      shorted <= 1'b0;
      #1;
      chk("backoff hold", 10'(DRV_OFF), 10'(drv));
      wait_drv(DRV_I1, "semi repoll");
      wait_drv(DRV_V1, "forced voltage phase");
      wait_drv(DRV_CLASS, "semi classify");
      wait_drv(DRV_OFF, "class done");
      rdchk(REG_STATUS, 10'h01c, "good class 3");
      chk("semi no power after good", 10'h0, 10'(power_on));
      wr(REG_CMD, 10'(1 << CMD_PWR_ON));
      rdchk(REG_FAULT, 10'h0, "no fault when good");
      chk("semi power on good", 10'h1, 10'(power_on));
      do_reset(1'b0);
      wr(REG_CTRL, HIP | 10'(MODE_SEMI));
      wr(REG_CMD, 10'(1 << CMD_PWR_ON));
      rdchk(REG_FAULT, 10'h1, "start fault");
      chk("semi refused power", 10'h0, 10'(power_on));
      wr(REG_FAULT, 10'h0);
      rdchk(REG_FAULT, 10'h0, "fault cleared");
      $display("test semi done");
      wr(REG_CTRL, HIP | 10'(MODE_MANUAL));
      wr(REG_CMD, 10'(1 << CMD_PWR_ON));
      rdchk(REG_STATUS, 10'h100, "forced power status");
      chk("forced power", 10'h1, 10'(power_on));
      wr(REG_ICUT, ICUT_C4);
      wr(REG_ILIM, ILIM_HI);
      rdchk(REG_ICUT, ICUT_C4, "icut while powered");
      rdchk(REG_ILIM, ILIM_HI, "ilim while powered");
      rdchk(REG_FAULT, 10'h0, "no fault in manual");
      wr(REG_CMD, 10'(1 << CMD_PWR_OFF));
      rdchk(REG_STATUS, 10'h0, "power removed");
      $display("test manual power done");
      do_reset(1'b1);
      cls <= 3'h4;
      rdchk(REG_CTRL, 10'h06f, "strap ctrl");
      wait_drv(DRV_I1, "auto detect start");
      wait_drv(DRV_MARK, "mark after class 4");
      @(posedge clk);
      cls <= 3'h2;
      wait_drv(DRV_OFF, "second class done");
      rdchk(REG_STATUS, 10'h014, "last class reported");
      rdchk(REG_HPSTAT, 10'h001, "second run flag");
      chk("type 2 mismatch refused", 10'h0, 10'(power_on));
      repeat (MIDSPAN_MS * TICK - 100) @(posedge clk);
      cls <= 3'h4;
      #1;
      chk("midspan backoff", 10'(DRV_OFF), 10'(drv));
      wait_drv(DRV_I1, "detect restart");
      wait_drv(DRV_OFF, "auto classify done");
      chk("auto power", 10'h1, 10'(power_on));
      rdchk(REG_ICUT, ICUT_C4, "class 4 icut");
      rdchk(REG_ILIM, ILIM_HI, "class 4 ilim");
      rdchk(REG_STATUS, 10'h124, "powered class 4");
      $display("test auto strap done");
      end_of_test();
   end
endmodule
`default_nettype wire
